// ==== gei_pkg.sv ====
// Constants and carrier types shared by the graphics event and interrupt unit.
// Assumes one clock domain; all offsets are byte addresses of 32-bit registers.
package gei_pkg;

  localparam int ADDR_W = 22;

  // Configuration space offsets
  localparam logic [7:0] CFG_SW_EVENT = 8'he0;
  localparam logic [7:0] CFG_DISP_EVENT = 8'he4;
  localparam logic [7:0] CFG_FW_STORE = 8'hfc;

  // Memory-mapped window and register offsets
  localparam logic [ADDR_W-1:0] MM_WIN_LO = 22'h181000;
  localparam logic [ADDR_W-1:0] MM_WIN_HI = 22'h182fff;
  localparam logic [ADDR_W-1:0] MM_ID_ALIAS = 22'h182084;
  localparam logic [ADDR_W-1:0] MM_SCRATCH0 = 22'h18209c;
  localparam logic [ADDR_W-1:0] MM_IRQ_ENABLE = 22'h1820a0;
  localparam logic [ADDR_W-1:0] MM_IRQ_IDENT = 22'h1820a4;
  localparam logic [ADDR_W-1:0] MM_IRQ_MASK = 22'h1820a8;
  localparam logic [ADDR_W-1:0] MM_IRQ_LIVE = 22'h1820ac;
  localparam logic [ADDR_W-1:0] MM_ERR_IDENT = 22'h1820b0;
  localparam logic [ADDR_W-1:0] MM_ERR_MASK = 22'h1820b4;
  localparam logic [ADDR_W-1:0] MM_ERR_LIVE = 22'h1820b8;
  localparam logic [ADDR_W-1:0] MM_PWR_CTX = 22'h182120;

  // Field positions
  localparam int SEL_BIT = 15;
  localparam int TRIG_BIT = 0;
  localparam int SCR_LO = 1;
  localparam int SCR_HI = 14;
  localparam int DISP_BIT = 0;
  localparam int MERR_BIT = 15;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [13:0] RST_SCRATCH = 14'h0;

  // One register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] be;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } gei_acc_t;

  // Answer to a register access
  typedef struct packed {
    logic ack;
    logic claim;
    logic [31:0] rdata;
  } gei_rsp_t;

endpackage

// ==== gei_sticky_bank.sv ====
// Bank of sticky status bits: hardware sets, software clears by writing one.
// Assumes set and clear inputs come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module gei_sticky_bank #(
  parameter int W = 32
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  output logic [W-1:0] o_bits
);

  typedef struct packed {
    logic [W-1:0] bits;
  } gei_sticky_t;

  gei_sticky_t st;
  gei_sticky_t next_st;

  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.bits = i_load_val;
    end
    next_st.bits = next_st.bits & ~i_clr;
    next_st.bits = next_st.bits | i_set;
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_bits = st.bits;

endmodule
`default_nettype wire

// ==== gei_event_msg.sv ====
// Upstream event message sender: holds SCI and SMI requests until the link takes them.
// Assumes the link accepts a message in any cycle where valid and ready are both high.
`timescale 1ns/1ns
`default_nettype none
module gei_event_msg (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req_sci,
  input wire logic i_req_smi,
  input wire logic i_msg_ready,
  output logic o_msg_valid,
  output logic o_msg_is_sci
);

  typedef struct packed {
    logic pend_sci;
    logic pend_smi;
    logic valid;
    logic is_sci;
  } gei_msg_t;

  gei_msg_t st;
  gei_msg_t next_st;

  always_comb begin
    next_st = st;
    if (st.valid && i_msg_ready) begin
      next_st.valid = 1'b0;
    end
    if (!next_st.valid) begin
      if (st.pend_sci) begin
        next_st.valid = 1'b1;
        next_st.is_sci = 1'b1;
        next_st.pend_sci = 1'b0;
      end else if (st.pend_smi) begin
        next_st.valid = 1'b1;
        next_st.is_sci = 1'b0;
        next_st.pend_smi = 1'b0;
      end
    end
    if (i_req_sci) begin
      next_st.pend_sci = 1'b1;
    end
    if (i_req_smi) begin
      next_st.pend_smi = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_msg_valid = st.valid;
  assign o_msg_is_sci = st.is_sci;

endmodule
`default_nettype wire

// ==== gei_event_irq.sv ====
// Event and interrupt unit of the graphics device: software event, display event,
// firmware storage, the interrupt identity, enable, mask and live status set, and the error identity, mask and live status set.
// Assumes the configuration and memory-mapped ports and the sources share i_mclk.
`timescale 1ns/1ns
`default_nettype none
module gei_event_irq #(
  parameter int IRQ_W = 32,
  parameter int ERR_W = 32
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire gei_pkg::gei_acc_t i_cfg,
  input wire gei_pkg::gei_acc_t i_mmio,
  input wire logic [IRQ_W-1:0] i_irq_src,
  input wire logic [ERR_W-1:0] i_err_src,
  input wire logic i_msg_ready,
  output gei_pkg::gei_rsp_t o_cfg_rsp,
  output gei_pkg::gei_rsp_t o_mmio_rsp,
  output logic o_cpu_irq,
  output logic o_msg_valid,
  output logic o_msg_is_sci
);

  typedef struct packed {
    logic sel;
    logic [13:0] scratch;
    logic trig;
    logic [31:0] disp;
    logic [31:0] fw;
    logic [31:0] scpd;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_msk;
    logic [ERR_W-1:0] err_msk;
    logic [31:0] pwr_ctx;
    logic disp_pulse;
    gei_pkg::gei_rsp_t cfg_rsp;
    gei_pkg::gei_rsp_t mm_rsp;
    logic cpu_irq;
  } gei_top_t;

  gei_top_t st;
  gei_top_t next_st;

  logic [IRQ_W-1:0] ident;
  logic [ERR_W-1:0] err_ident;
  logic [IRQ_W-1:0] live_stat;
  logic [IRQ_W-1:0] ident_set;
  logic [IRQ_W-1:0] ident_clr;
  logic ident_load;
  logic [IRQ_W-1:0] ident_load_val;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic req_sci;
  logic req_smi;
  logic cfg_wr_sw;
  logic cfg_wr_disp;
  logic cfg_wr_fw;
  logic mm_hit;
  logic mm_wr;
  logic [31:0] mm_wmask;
  logic [31:0] sw_word;
  logic [31:0] sw_new;

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Word mask with ones in the enabled byte lanes
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] res;
    res = '0;
    for (int b = 0; b < 4; b++) begin
      res[8*b +: 8] = {8{be[b]}};
    end
    return res;
  endfunction

  // Configuration write decode
  always_comb begin
    cfg_wr_sw = i_cfg.wr && (i_cfg.addr[7:0] == gei_pkg::CFG_SW_EVENT);
    cfg_wr_disp = i_cfg.wr && (i_cfg.addr[7:0] == gei_pkg::CFG_DISP_EVENT);
    cfg_wr_fw = i_cfg.wr && (i_cfg.addr[7:0] == gei_pkg::CFG_FW_STORE);
  end

  // Software event register as a 32-bit word
  always_comb begin
    sw_word = gei_pkg::RST_WORD;
    sw_word[gei_pkg::SEL_BIT] = st.sel;
    sw_word[gei_pkg::SCR_HI:gei_pkg::SCR_LO] = st.scratch;
    sw_word[gei_pkg::TRIG_BIT] = st.trig;
    sw_new = merge(sw_word, i_cfg.wdata, i_cfg.be);
  end

  // Software event requests from trigger transitions
  always_comb begin
    req_sci = 1'b0;
    req_smi = 1'b0;
    if (cfg_wr_sw && !st.trig && sw_new[gei_pkg::TRIG_BIT]) begin
      if (sw_new[gei_pkg::SEL_BIT]) begin
        req_sci = 1'b1;
      end else begin
        req_smi = 1'b1;
      end
    end
  end

  // Memory-mapped window decode
  always_comb begin
    mm_hit = (i_mmio.addr >= gei_pkg::MM_WIN_LO) && (i_mmio.addr <= gei_pkg::MM_WIN_HI);
    mm_wr = i_mmio.wr && mm_hit;
    mm_wmask = lane_mask(i_mmio.be);
  end

  // Live interrupt status
  always_comb begin
    live_stat = i_irq_src;
    live_stat[gei_pkg::DISP_BIT] = st.disp_pulse;
    live_stat[gei_pkg::MERR_BIT] = |err_ident;
  end

  // Identity latch controls
  always_comb begin
    ident_set = live_stat & ~st.irq_msk;
    ident_clr = '0;
    ident_load = 1'b0;
    ident_load_val = ident;
    if (mm_wr && (i_mmio.addr == gei_pkg::MM_IRQ_IDENT)) begin
      ident_clr = i_mmio.wdata[IRQ_W-1:0] & mm_wmask[IRQ_W-1:0];
    end
    if (mm_wr && (i_mmio.addr == gei_pkg::MM_ID_ALIAS)) begin
      ident_load = 1'b1;
      ident_load_val = IRQ_W'(merge(32'(ident), i_mmio.wdata, i_mmio.be));
    end
  end

  // Error latch controls
  always_comb begin
    err_set = i_err_src & ~st.err_msk;
    err_clr = '0;
    if (mm_wr && (i_mmio.addr == gei_pkg::MM_ERR_IDENT)) begin
      err_clr = i_mmio.wdata[ERR_W-1:0] & mm_wmask[ERR_W-1:0];
    end
  end

  gei_sticky_bank #(
    .W(IRQ_W)
  ) u_irq_ident (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_set(ident_set),
    .i_clr(ident_clr),
    .i_load(ident_load),
    .i_load_val(ident_load_val),
    .o_bits(ident)
  );

  gei_sticky_bank #(
    .W(ERR_W)
  ) u_err_ident (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_set(err_set),
    .i_clr(err_clr),
    .i_load(1'b0),
    .i_load_val('0),
    .o_bits(err_ident)
  );

  gei_event_msg u_msg (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_req_sci(req_sci),
    .i_req_smi(req_smi),
    .i_msg_ready(i_msg_ready),
    .o_msg_valid(o_msg_valid),
    .o_msg_is_sci(o_msg_is_sci)
  );

  // Register state update
  always_comb begin
    next_st = st;
    next_st.disp_pulse = 1'b0;
    if (cfg_wr_sw) begin
      next_st.sel = sw_new[gei_pkg::SEL_BIT];
      next_st.scratch = sw_new[gei_pkg::SCR_HI:gei_pkg::SCR_LO];
      next_st.trig = sw_new[gei_pkg::TRIG_BIT];
    end
    if (cfg_wr_disp) begin
      next_st.disp = merge(st.disp, i_cfg.wdata, i_cfg.be);
      next_st.disp_pulse = |i_cfg.be;
    end
    if (cfg_wr_fw) begin
      next_st.fw = merge(st.fw, i_cfg.wdata, i_cfg.be);
    end
    if (mm_wr) begin
      unique case (i_mmio.addr)
        gei_pkg::MM_SCRATCH0: begin
          next_st.scpd = merge(st.scpd, i_mmio.wdata, i_mmio.be);
        end
        gei_pkg::MM_IRQ_ENABLE: begin
          next_st.irq_en = IRQ_W'(merge(32'(st.irq_en), i_mmio.wdata, i_mmio.be));
        end
        gei_pkg::MM_IRQ_MASK: begin
          next_st.irq_msk = IRQ_W'(merge(32'(st.irq_msk), i_mmio.wdata, i_mmio.be));
        end
        gei_pkg::MM_ERR_MASK: begin
          next_st.err_msk = ERR_W'(merge(32'(st.err_msk), i_mmio.wdata, i_mmio.be));
        end
        gei_pkg::MM_PWR_CTX: begin
          next_st.pwr_ctx = merge(st.pwr_ctx, i_mmio.wdata, i_mmio.be);
        end
        default: begin
        end
      endcase
    end

    // Configuration answers
    next_st.cfg_rsp.ack = i_cfg.wr || i_cfg.rd;
    next_st.cfg_rsp.claim = i_cfg.wr || i_cfg.rd;
    next_st.cfg_rsp.rdata = gei_pkg::RST_WORD;
    if (i_cfg.rd) begin
      unique case (i_cfg.addr[7:0])
        gei_pkg::CFG_SW_EVENT: begin
          next_st.cfg_rsp.rdata = sw_word;
        end
        gei_pkg::CFG_DISP_EVENT: begin
          next_st.cfg_rsp.rdata = st.disp;
        end
        gei_pkg::CFG_FW_STORE: begin
          next_st.cfg_rsp.rdata = st.fw;
        end
        default: begin
        end
      endcase
    end

    // Memory-mapped answers; unmapped offsets in the window read zero
    next_st.mm_rsp.ack = (i_mmio.wr || i_mmio.rd) && mm_hit;
    next_st.mm_rsp.claim = (i_mmio.wr || i_mmio.rd) && mm_hit;
    next_st.mm_rsp.rdata = gei_pkg::RST_WORD;
    if (i_mmio.rd && mm_hit) begin
      unique case (i_mmio.addr)
        gei_pkg::MM_ID_ALIAS, gei_pkg::MM_IRQ_IDENT: begin
          next_st.mm_rsp.rdata = 32'(ident);
        end
        gei_pkg::MM_SCRATCH0: begin
          next_st.mm_rsp.rdata = st.scpd;
        end
        gei_pkg::MM_IRQ_ENABLE: begin
          next_st.mm_rsp.rdata = 32'(st.irq_en);
        end
        gei_pkg::MM_IRQ_MASK: begin
          next_st.mm_rsp.rdata = 32'(st.irq_msk);
        end
        gei_pkg::MM_IRQ_LIVE: begin
          next_st.mm_rsp.rdata = 32'(live_stat);
        end
        gei_pkg::MM_ERR_IDENT: begin
          next_st.mm_rsp.rdata = 32'(err_ident);
        end
        gei_pkg::MM_ERR_MASK: begin
          next_st.mm_rsp.rdata = 32'(st.err_msk);
        end
        gei_pkg::MM_ERR_LIVE: begin
          next_st.mm_rsp.rdata = 32'(i_err_src);
        end
        gei_pkg::MM_PWR_CTX: begin
          next_st.mm_rsp.rdata = st.pwr_ctx;
        end
        default: begin
        end
      endcase
    end

    next_st.cpu_irq = |(ident & st.irq_en);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st.sel <= 1'b0;
      st.scratch <= gei_pkg::RST_SCRATCH;
      st.trig <= 1'b0;
      st.disp <= gei_pkg::RST_WORD;
      st.fw <= gei_pkg::RST_WORD;
      st.scpd <= gei_pkg::RST_WORD;
      st.irq_en <= '0;
      st.irq_msk <= '0;
      st.err_msk <= '0;
      st.pwr_ctx <= gei_pkg::RST_WORD;
      st.disp_pulse <= 1'b0;
      st.cfg_rsp <= '0;
      st.mm_rsp <= '0;
      st.cpu_irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_cfg_rsp = st.cfg_rsp;
  assign o_mmio_rsp = st.mm_rsp;
  assign o_cpu_irq = st.cpu_irq;

endmodule
`default_nettype wire

// ==== gei_event_irq_asserts.sv ====
// Port-level checks for the graphics event and interrupt unit.
// Assumes it is bound to gei_event_irq and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module gei_event_irq_asserts #(
  parameter int IRQ_W = 32,
  parameter int ERR_W = 32
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire gei_pkg::gei_acc_t i_cfg,
  input wire gei_pkg::gei_acc_t i_mmio,
  input wire logic [IRQ_W-1:0] i_irq_src,
  input wire logic [ERR_W-1:0] i_err_src,
  input wire logic i_msg_ready,
  input wire gei_pkg::gei_rsp_t o_cfg_rsp,
  input wire gei_pkg::gei_rsp_t o_mmio_rsp,
  input wire logic o_cpu_irq,
  input wire logic o_msg_valid,
  input wire logic o_msg_is_sci
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  logic trig_q, sel_q, en0_q, msk0_q, sw_rd_q;
  logic in_win, sw_wr, sel_new, sci_rise, smi_rise, disp_wr;
  assign in_win = i_mmio.addr >= gei_pkg::MM_WIN_LO && i_mmio.addr <= gei_pkg::MM_WIN_HI;
  assign sw_wr = i_cfg.wr && i_cfg.addr[7:0] == gei_pkg::CFG_SW_EVENT && i_cfg.be[0];
  assign sel_new = i_cfg.be[1] ? i_cfg.wdata[15] : sel_q;
  assign sci_rise = sw_wr && i_cfg.wdata[0] && !trig_q && sel_new;
  assign smi_rise = sw_wr && i_cfg.wdata[0] && !trig_q && !sel_new;
  assign disp_wr = i_cfg.wr && i_cfg.addr[7:0] == gei_pkg::CFG_DISP_EVENT && (|i_cfg.be);
  // Shadows of the software-visible bits that qualify events, and a registered flag for a software event register read
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      trig_q <= 1'b0;
      sel_q <= 1'b0;
      en0_q <= 1'b0;
      msk0_q <= 1'b0;
      sw_rd_q <= 1'b0;
    end else begin
      if (sw_wr) begin
        trig_q <= i_cfg.wdata[0];
      end
      if (i_cfg.wr && i_cfg.addr[7:0] == gei_pkg::CFG_SW_EVENT && i_cfg.be[1]) begin
        sel_q <= i_cfg.wdata[15];
      end
      if (i_mmio.wr && i_mmio.addr == gei_pkg::MM_IRQ_ENABLE && i_mmio.be[0]) begin
        en0_q <= i_mmio.wdata[0];
      end
      if (i_mmio.wr && i_mmio.addr == gei_pkg::MM_IRQ_MASK && i_mmio.be[0]) begin
        msk0_q <= i_mmio.wdata[0];
      end
      sw_rd_q <= i_cfg.rd && i_cfg.addr[7:0] == gei_pkg::CFG_SW_EVENT;
    end
  end
  sequence s_stalled;
    o_msg_valid && !i_msg_ready;
  endsequence
  sequence s_sci_out;
    ##[1:20] (o_msg_valid && o_msg_is_sci);
  endsequence
  sequence s_smi_out;
    ##[1:20] (o_msg_valid && !o_msg_is_sci);
  endsequence
  AST_SCI_SENT: assert property (sci_rise |-> s_sci_out)
    else $error("software event with select set gave no SCI message");
  AST_SMI_SENT: assert property (smi_rise |-> s_smi_out)
    else $error("software event with select clear gave no SMI message");
  AST_MSG_HOLD: assert property (s_stalled |=> o_msg_valid && $stable(o_msg_is_sci))
    else $error("event message dropped or changed before acceptance");
  AST_DISP_IRQ: assert property (disp_wr && en0_q && !msk0_q |-> ##[1:4] o_cpu_irq)
    else $error("display event write did not raise the cpu interrupt");
  AST_MMIO_CLAIM: assert property ((i_mmio.wr || i_mmio.rd) && in_win |=> o_mmio_rsp.ack && o_mmio_rsp.claim)
    else $error("in-window access not claimed");
  AST_MMIO_SKIP: assert property ((i_mmio.wr || i_mmio.rd) && !in_win |=> !o_mmio_rsp.ack && !o_mmio_rsp.claim)
    else $error("out-of-window access claimed");
  AST_SW_UPPER: assert property (o_cfg_rsp.ack && sw_rd_q |-> o_cfg_rsp.rdata[31:16] == 16'h0)
    else $error("software event register upper half not zero");
  AST_RESET_QUIET: assert property ($rose(i_nrst) |-> !o_msg_valid && !o_cpu_irq && !o_cfg_rsp.ack)
    else $error("outputs active right after reset");
endmodule
bind gei_event_irq gei_event_irq_asserts #(.IRQ_W(IRQ_W), .ERR_W(ERR_W)) gei_event_irq_asserts_inst (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_cfg(i_cfg), .i_mmio(i_mmio), .i_irq_src(i_irq_src),
  .i_err_src(i_err_src), .i_msg_ready(i_msg_ready), .o_cfg_rsp(o_cfg_rsp), .o_mmio_rsp(o_mmio_rsp),
  .o_cpu_irq(o_cpu_irq), .o_msg_valid(o_msg_valid), .o_msg_is_sci(o_msg_is_sci));
`default_nettype wire

// ==== gei_link_model.sv ====
// Upstream event message link: accepts messages and counts them by kind.
// Assumes one clock with the unit; slow mode takes a message after two wait cycles.
`timescale 1ns/1ns
`default_nettype none
module gei_link_model (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic i_is_sci,
  input wire logic i_slow,
  output logic o_ready,
  output logic [7:0] o_n_sci,
  output logic [7:0] o_n_smi
);
  logic [1:0] wt;
  assign o_ready = i_valid && (!i_slow || wt == 2'h2);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wt <= 2'h0;
      o_n_sci <= 8'h0;
      o_n_smi <= 8'h0;
    end else if (i_valid && o_ready) begin
      wt <= 2'h0;
      o_n_sci <= o_n_sci + {7'h0, i_is_sci};
      o_n_smi <= o_n_smi + {7'h0, !i_is_sci};
    end else if (i_valid) begin
      wt <= wt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the graphics event and interrupt unit.
// Assumes the unit, its link partner model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [21:0] SW = 22'(gei_pkg::CFG_SW_EVENT);
  localparam logic [21:0] DISP = 22'(gei_pkg::CFG_DISP_EVENT);
  localparam logic [21:0] FW = 22'(gei_pkg::CFG_FW_STORE);
  logic i_mclk, i_nrst, slow, acked, cl, cpu_irq, msg_valid, msg_sci, msg_ready;
  gei_pkg::gei_acc_t cfg, mmio;
  gei_pkg::gei_rsp_t cfg_rsp, mmio_rsp;
  logic [31:0] irq_src, err_src, q;
  logic [7:0] n_sci, n_smi;
  int n_fail = 0;
  int num_checks = 0;
  gei_event_irq gei_event_irq_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_cfg(cfg), .i_mmio(mmio),
    .i_irq_src(irq_src), .i_err_src(err_src), .i_msg_ready(msg_ready), .o_cfg_rsp(cfg_rsp),
    .o_mmio_rsp(mmio_rsp), .o_cpu_irq(cpu_irq), .o_msg_valid(msg_valid), .o_msg_is_sci(msg_sci));
  gei_link_model gei_link_model_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_valid(msg_valid),
    .i_is_sci(msg_sci), .i_slow(slow), .o_ready(msg_ready), .o_n_sci(n_sci), .o_n_smi(n_smi));
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One access on either port; the answer is awaited for a bounded count
  task automatic acc(input logic mm, input logic w, input logic [21:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    gei_pkg::gei_acc_t r;
    r = '{wr: w, rd: !w, be: be, addr: a, wdata: d};
    @(negedge i_mclk);
    if (mm) mmio = r;
    else cfg = r;
    @(negedge i_mclk);
    mmio = '0;
    cfg = '0;
    acked = 1'b0;
    for (int k = 0; k < 4 && !acked; k++) begin
      if ((mm ? mmio_rsp.ack : cfg_rsp.ack) === 1'b1) begin
        acked = 1'b1;
        q = mm ? mmio_rsp.rdata : cfg_rsp.rdata;
        cl = mm ? mmio_rsp.claim : cfg_rsp.claim;
      end else begin
        @(negedge i_mclk);
      end
    end
  endtask
  task automatic wr(input logic mm, input logic [21:0] a, input logic [31:0] d);
    acc(mm, 1'b1, a, 4'hf, d);
    chk({31'h0, acked}, 32'h1);
  endtask
  task automatic rd(input logic mm, input logic [21:0] a, input logic [31:0] e);
    acc(mm, 1'b0, a, 4'hf, 32'h0);
    chk({31'h0, acked}, 32'h1);
    chk({31'h0, cl}, 32'h1);
    chk(q, e);
  endtask
  task automatic wait_irq(input logic e);
    for (int k = 0; k < 6 && cpu_irq !== e; k++) @(negedge i_mclk);
    chk({31'h0, cpu_irq}, {31'h0, e});
  endtask
  task automatic pulse(input logic err, input logic [31:0] v);
    @(negedge i_mclk);
    if (err) err_src = v;
    else irq_src = v;
    @(negedge i_mclk);
    err_src = 32'h0;
    irq_src = 32'h0;
    repeat (2) @(negedge i_mclk);
  endtask
  task automatic t_reset_vals();
    logic [21:0] regs[8] = '{gei_pkg::MM_ID_ALIAS, gei_pkg::MM_SCRATCH0, gei_pkg::MM_IRQ_ENABLE,
      gei_pkg::MM_IRQ_IDENT, gei_pkg::MM_IRQ_MASK, gei_pkg::MM_ERR_IDENT, gei_pkg::MM_ERR_MASK, gei_pkg::MM_PWR_CTX};
    foreach (regs[i]) rd(1'b1, regs[i], 32'h0);
    rd(1'b0, FW, 32'h0);
    $display("done reset values");
  endtask
  task automatic t_sw_event();
    slow = 1'b1;
    wr(1'b0, SW, 32'h0000_8001);
    repeat (8) @(negedge i_mclk);
    chk({24'h0, n_sci}, 32'h1);
    wr(1'b0, SW, 32'h0000_8001);
    repeat (8) @(negedge i_mclk);
    chk({24'h0, n_sci}, 32'h1);
    // Trigger cleared before rearming
    wr(1'b0, SW, 32'h0000_8000);
    slow = 1'b0;
    wr(1'b0, SW, 32'h0000_0001);
    repeat (8) @(negedge i_mclk);
    chk({24'h0, n_smi}, 32'h1);
    chk({24'h0, n_sci}, 32'h1);
    wr(1'b0, SW, 32'hffff_7ffe);
    rd(1'b0, SW, 32'h0000_7ffe);
    $display("done software event");
  endtask
  task automatic t_display();
    wr(1'b1, gei_pkg::MM_IRQ_ENABLE, 32'h1);
    wr(1'b1, gei_pkg::MM_IRQ_MASK, 32'h0);
    wr(1'b0, DISP, 32'h1234_5678);
    wait_irq(1'b1);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h1);
    rd(1'b0, DISP, 32'h1234_5678);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h1);
    wait_irq(1'b0);
    acc(1'b0, 1'b1, DISP, 4'h1, 32'h0000_0078);
    wait_irq(1'b1);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h1);
    wr(1'b1, gei_pkg::MM_IRQ_MASK, 32'h1);
    wr(1'b0, DISP, 32'h0);
    repeat (4) @(negedge i_mclk);
    chk({31'h0, cpu_irq}, 32'h0);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h0);
    wr(1'b1, gei_pkg::MM_ID_ALIAS, 32'h2);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h2);
    chk({31'h0, cpu_irq}, 32'h0);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h2);
    $display("done display event");
  endtask
  task automatic t_sources();
    wr(1'b1, gei_pkg::MM_IRQ_ENABLE, 32'h0);
    wr(1'b1, gei_pkg::MM_IRQ_MASK, 32'h40);
    pulse(1'b0, 32'h60);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h20);
    chk({31'h0, cpu_irq}, 32'h0);
    rd(1'b1, gei_pkg::MM_IRQ_LIVE, 32'h0);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h0);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h20);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h20);
    irq_src = 32'h200;
    wr(1'b1, gei_pkg::MM_IRQ_LIVE, 32'hffff);
    rd(1'b1, gei_pkg::MM_IRQ_LIVE, 32'h200);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h200);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h200);
    irq_src = 32'h0;
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h200);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h0);
    $display("done sources");
  endtask
  task automatic t_errors();
    wr(1'b1, gei_pkg::MM_IRQ_MASK, 32'h0);
    wr(1'b1, gei_pkg::MM_ERR_MASK, 32'h10);
    pulse(1'b1, 32'h18);
    rd(1'b1, gei_pkg::MM_ERR_IDENT, 32'h8);
    rd(1'b1, gei_pkg::MM_ERR_LIVE, 32'h0);
    rd(1'b1, gei_pkg::MM_IRQ_LIVE, 32'h8000);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h8000);
    err_src = 32'h10;
    rd(1'b1, gei_pkg::MM_ERR_LIVE, 32'h10);
    err_src = 32'h0;
    // Latched errors cleared before the master bit
    wr(1'b1, gei_pkg::MM_ERR_IDENT, 32'h8);
    rd(1'b1, gei_pkg::MM_IRQ_LIVE, 32'h0);
    wr(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h8000);
    rd(1'b1, gei_pkg::MM_IRQ_IDENT, 32'h0);
    $display("done errors");
  endtask
  task automatic t_misc();
    wr(1'b0, FW, 32'ha5a5_5a5a);
    rd(1'b0, FW, 32'ha5a5_5a5a);
    wr(1'b1, gei_pkg::MM_SCRATCH0, 32'h1357_9bdf);
    rd(1'b1, gei_pkg::MM_SCRATCH0, 32'h1357_9bdf);
    rd(1'b1, 22'h182ffc, 32'h0);
    rd(1'b0, 22'h000040, 32'h0);
    acc(1'b1, 1'b0, 22'h180ffc, 4'hf, 32'h0);
    chk({31'h0, acked}, 32'h0);
    acc(1'b1, 1'b1, 22'h183000, 4'hf, 32'h0);
    chk({31'h0, acked}, 32'h0);
    $display("done misc");
  endtask
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_fail++;
    test_done();
  end
  initial begin
    i_nrst = 1'b0;
    slow = 1'b0;
    cfg = '0;
    mmio = '0;
    irq_src = 32'h0;
    err_src = 32'h0;
    acked = 1'b0;
    cl = 1'b0;
    q = 32'h0;
    repeat (16) @(negedge i_mclk);
    i_nrst = 1'b1;
    t_reset_vals();
    t_sw_event();
    t_display();
    t_sources();
    t_errors();
    t_misc();
    test_done();
  end
endmodule
`default_nettype wire
